// >>> rtl/flash_supervisor_pkg.sv
// shared constants for the flash programming supervisor
package flash_supervisor_pkg;

  // ----------------------------------------------------------------
  // cpu side encodings
  // ----------------------------------------------------------------
  localparam logic [7:0]  OPC_SUPERVISOR_CALL = 8'h00;  // trap into rom
  localparam logic [7:0]  OPC_RETURN_FROM_INT = 8'h7e;  // arbitrary encoding
  localparam int          FLAG_SUPERVISOR_BIT = 3;      // flag set on entry
  localparam logic [15:0] ROM_ENTRY_ADDR      = 16'h0000;
  localparam logic [15:0] SERVICE_TABLE_BASE  = 16'h0002;  // jump table after entry
  localparam logic [7:0]  FLAGS_RESET         = 8'h00;
  localparam logic [15:0] PC_RESET            = 16'h0000;

  // ----------------------------------------------------------------
  // serial link framing
  // ----------------------------------------------------------------
  localparam int          FRAME_BITS   = 24;   // command, argument, data
  localparam int          REPLY_BITS   = 16;
  localparam logic [4:0]  FRAME_LAST   = 5'h17;
  localparam logic [4:0]  REPLY_LAST   = 5'h0f;
  localparam int          FIFO_DEPTH   = 16;

  // ----------------------------------------------------------------
  // programmer commands
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_WRITE_BYTE     = 8'h01;
  localparam logic [7:0] CMD_CLOCK_RATE     = 8'h02;  // clock_rate_param
  localparam logic [7:0] CMD_SET_BLOCK      = 8'h03;
  localparam logic [7:0] CMD_ERASE_ALL      = 8'h04;
  localparam logic [7:0] CMD_PROGRAM_BLOCK  = 8'h05;
  localparam logic [7:0] CMD_VERIFY_SETUP   = 8'h06;
  localparam logic [7:0] CMD_READ_BYTE      = 8'h07;
  localparam logic [7:0] CMD_IDENTITY_SETUP = 8'h08;
  localparam logic [7:0] CMD_IDENTITY_READ  = 8'h09;
  localparam logic [7:0] CMD_WRITE_SECURITY = 8'h0a;
  localparam logic [7:0] CMD_PROTECT_COMMIT = 8'h0b;

  // ----------------------------------------------------------------
  // flash geometry and timing
  // ----------------------------------------------------------------
  localparam int          BLOCK_BYTES      = 64;
  localparam logic [5:0]  BYTE_LAST        = 6'h3f;
  localparam logic [7:0]  CLOCK_RATE_RESET = 8'h01;
  localparam logic [15:0] UNIT_CYCLES      = 16'h0010;  // wait cycles per rate unit
  localparam logic [15:0] IDENTITY_WORD    = 16'h5a3c;  // arbitrary value

endpackage

// >>> rtl/word_fifo.sv
// synchronous word fifo with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];  // storage in flops
  logic [AW-1:0]    wr_reg;           // write index
  logic [AW-1:0]    rd_reg;           // read index
  logic [AW:0]      count_reg;        // words held

  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;

  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem_reg[rd_reg];

  // storage write, no reset needed on data
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  // pointers and occupancy
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_reg    <= '0;
      rd_reg    <= '0;
      count_reg <= '0;
    end else begin
      if (push) wr_reg <= wr_reg + AW'(1);
      if (pop)  rd_reg <= rd_reg + AW'(1);
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule
`default_nettype wire

// >>> rtl/flash_program_supervisor.sv
// supervisor call entry and serial flash programming engine
`timescale 1ns/10ps
`default_nettype none
module flash_program_supervisor
  import flash_supervisor_pkg::*;
(
  // core clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // cpu instruction side
  input  wire logic        CPU_OP_VALID,
  input  wire logic [7:0]  CPU_OPCODE,
  input  wire logic [7:0]  CPU_FLAGS,
  input  wire logic [15:0] CPU_PC,
  input  wire logic [7:0]  CPU_ACC,
  output logic             PC_LOAD,
  output logic [15:0]      PC_NEXT,
  output logic             FLAGS_LOAD,
  output logic [7:0]       FLAGS_NEXT,
  output logic             STACK_PUSH,
  output logic [7:0]       STACK_DATA,
  // flash array
  output logic [13:0]      FL_ADDR,
  output logic             FL_WE,
  output logic [7:0]       FL_WDATA,
  output logic             FL_ERASE,
  input  wire logic [7:0]  FL_RDATA,
  // serial programming link
  input  wire logic        PROG_SCLK,
  input  wire logic        PROG_DATA_IN,
  output logic             PROG_DATA_OUT,
  output logic             PROG_DATA_OE
);

  // ----------------------------------------------------------------
  // cpu trap sequencer
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    T_IDLE = 5'b00001, T_PUSH_LO = 5'b00010, T_PUSH_FL = 5'b00100,
    T_ENTRY = 5'b01000, T_JUMP = 5'b10000
  } trap_t;

  trap_t       trap_reg;     // trap sequence step
  logic [15:0] pc_save_reg;  // old program counter
  logic [7:0]  fl_save_reg;  // flags at the call
  logic [7:0]  acc_reg;      // second level function code

  wire is_call = CPU_OP_VALID && (CPU_OPCODE == OPC_SUPERVISOR_CALL) && (trap_reg == T_IDLE);
  wire is_ret  = CPU_OP_VALID && (CPU_OPCODE == OPC_RETURN_FROM_INT) && (trap_reg == T_IDLE);
  wire [15:0] jump_target = SERVICE_TABLE_BASE + {7'h00, acc_reg, 1'b0};

  // flag image with the supervisor bit forced
  function automatic logic [7:0] with_sup(input logic [7:0] f, input logic v);
    logic [7:0] r;
    r = f;
    r[FLAG_SUPERVISOR_BIT] = v;
    return r;
  endfunction

  // call pushes three bytes, then vectors, then dispatches
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      trap_reg    <= T_IDLE;
      pc_save_reg <= PC_RESET;
      fl_save_reg <= FLAGS_RESET;
      acc_reg     <= 8'h00;
      PC_LOAD     <= 1'b0;
      PC_NEXT     <= PC_RESET;
      FLAGS_LOAD  <= 1'b0;
      FLAGS_NEXT  <= FLAGS_RESET;
      STACK_PUSH  <= 1'b0;
      STACK_DATA  <= 8'h00;
    end else begin
      PC_LOAD    <= 1'b0;
      FLAGS_LOAD <= 1'b0;
      STACK_PUSH <= 1'b0;
      unique case (trap_reg)
        T_IDLE: begin
          if (is_call) begin
            pc_save_reg <= CPU_PC;
            fl_save_reg <= CPU_FLAGS;
            acc_reg     <= CPU_ACC;
            STACK_PUSH  <= 1'b1;
            STACK_DATA  <= CPU_PC[15:8];
            trap_reg    <= T_PUSH_LO;
          end else if (is_ret) begin
            FLAGS_LOAD  <= 1'b1;
            FLAGS_NEXT  <= with_sup(CPU_FLAGS, 1'b0);
            PC_LOAD     <= 1'b1;
            PC_NEXT     <= CPU_PC;
          end
        end
        T_PUSH_LO: begin
          STACK_PUSH <= 1'b1;
          STACK_DATA <= pc_save_reg[7:0];
          trap_reg   <= T_PUSH_FL;
        end
        T_PUSH_FL: begin
          STACK_PUSH <= 1'b1;
          STACK_DATA <= with_sup(fl_save_reg, 1'b1);
          trap_reg   <= T_ENTRY;
        end
        T_ENTRY: begin
          FLAGS_LOAD <= 1'b1;
          FLAGS_NEXT <= with_sup(fl_save_reg, 1'b1);
          PC_LOAD    <= 1'b1;
          PC_NEXT    <= ROM_ENTRY_ADDR;
          trap_reg   <= T_JUMP;
        end
        T_JUMP: begin
          PC_LOAD  <= 1'b1;
          PC_NEXT  <= jump_target;
          trap_reg <= T_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // link domain: frame receiver and poll driver
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    L_IDLE = 6'b000001, L_SHIFT = 6'b000010, L_HAND = 6'b000100,
    L_BUSY = 6'b001000, L_DONE = 6'b010000, L_REPLY = 6'b100000
  } link_t;

  link_t       link_reg;              // link state
  logic [1:0]  lrst_reg;              // reset synchroniser
  logic [1:0]  din_reg;               // data pin synchroniser
  logic [23:0] shift_reg;             // incoming frame
  logic [4:0]  bit_reg;               // bit counter
  logic        req_tog_reg;           // frame ready toggle
  logic [1:0]  ack_sync_reg;          // ack toggle synchroniser
  logic        ack_seen_reg;          // last ack level
  logic [1:0]  done_sync_reg;         // done toggle synchroniser
  logic        done_seen_reg;         // last done level
  logic [15:0] tx_reg;                // reply shifter
  logic        tx_en_reg;             // reply expected
  logic        ack_tog_reg;           // frame accepted toggle
  logic        done_tog_reg;          // operation finished toggle
  logic [15:0] reply_reg;             // reply word
  logic        reply_en_reg;          // reply follows poll

  wire link_rst_n = lrst_reg[1];
  wire din        = din_reg[1];

  // reset and pin synchronisers on the link clock
  always_ff @(posedge PROG_SCLK) begin
    lrst_reg      <= {lrst_reg[0], RST_N};
    din_reg       <= {din_reg[0], PROG_DATA_IN && !PROG_DATA_OE};  // own drive masked
  end

  // line driven high while busy, low when done
  always_ff @(posedge PROG_SCLK) begin
    ack_sync_reg  <= {ack_sync_reg[0], ack_tog_reg};
    done_sync_reg <= {done_sync_reg[0], done_tog_reg};
    if (!link_rst_n) begin
      link_reg      <= L_IDLE;
      shift_reg     <= 24'h000000;
      bit_reg       <= 5'h00;
      req_tog_reg   <= 1'b0;
      ack_seen_reg  <= 1'b0;
      done_seen_reg <= 1'b0;
      tx_reg        <= 16'h0000;
      tx_en_reg     <= 1'b0;
      PROG_DATA_OUT <= 1'b0;
      PROG_DATA_OE  <= 1'b0;
    end else begin
      unique case (link_reg)
        L_IDLE: begin
          PROG_DATA_OE <= 1'b0;
          bit_reg      <= 5'h00;
          if (din) link_reg <= L_SHIFT;  // start bit
        end
        L_SHIFT: begin
          shift_reg <= {shift_reg[22:0], din};
          bit_reg   <= bit_reg + 5'h01;
          if (bit_reg == FRAME_LAST) begin
            req_tog_reg <= ~req_tog_reg;
            link_reg    <= L_HAND;
            // take the line at once so the host sees busy
            PROG_DATA_OE  <= 1'b1;
            PROG_DATA_OUT <= 1'b1;
          end
        end
        L_HAND: begin
          if (ack_sync_reg[1] != ack_seen_reg) begin
            ack_seen_reg <= ack_sync_reg[1];
            link_reg     <= L_BUSY;
          end
        end
        L_BUSY: begin
          if (done_sync_reg[1] != done_seen_reg) begin
            done_seen_reg <= done_sync_reg[1];
            tx_reg        <= reply_reg;    // stable since before toggle
            tx_en_reg     <= reply_en_reg;
            PROG_DATA_OUT <= 1'b0;
            link_reg      <= L_DONE;
          end
        end
        L_DONE: begin
          bit_reg <= 5'h00;
          if (tx_en_reg) begin
            PROG_DATA_OUT <= tx_reg[15];
            tx_reg        <= {tx_reg[14:0], 1'b0};
            link_reg      <= L_REPLY;
          end else begin
            PROG_DATA_OE <= 1'b0;
            link_reg     <= L_IDLE;
          end
        end
        L_REPLY: begin
          bit_reg       <= bit_reg + 5'h01;
          PROG_DATA_OUT <= tx_reg[15];
          tx_reg        <= {tx_reg[14:0], 1'b0};
          if (bit_reg == REPLY_LAST - 5'h01) begin
            link_reg <= L_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // core domain: frame capture into the fifo
  // ----------------------------------------------------------------
  logic [2:0]  req_sync_reg;   // two sync stages plus history
  logic        pend_reg;       // frame waiting for fifo space
  wire         fifo_in_ready;
  wire         fifo_out_valid;
  wire  [23:0] fifo_out_data;
  logic        pop_reg;        // executor takes a word

  wire req_edge = req_sync_reg[2] != req_sync_reg[1];

  // frame word is stable in the link shifter until acknowledged
  always_ff @(posedge CLK) begin
    req_sync_reg <= {req_sync_reg[1:0], req_tog_reg};
    if (!RST_N) begin
      ack_tog_reg <= 1'b0;
      pend_reg    <= 1'b0;
    end else if (pend_reg || req_edge) begin
      pend_reg <= !fifo_in_ready;
      if (fifo_in_ready) ack_tog_reg <= ~ack_tog_reg;
    end
  end

  word_fifo #(.WIDTH(FRAME_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (CLK),
    .rst_n     (RST_N),
    .in_valid  (pend_reg || req_edge),
    .in_ready  (fifo_in_ready),
    .in_data   (shift_reg),
    .out_valid (fifo_out_valid),
    .out_ready (pop_reg),
    .out_data  (fifo_out_data)
  );

  // ----------------------------------------------------------------
  // core domain: command executor
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    E_IDLE = 5'b00001, E_EXEC = 5'b00010, E_WRITE = 5'b00100,
    E_WAIT = 5'b01000, E_READ = 5'b10000
  } exec_t;

  exec_t       exec_reg;                  // executor state
  logic [7:0]  page_reg [BLOCK_BYTES];    // block load buffer
  logic [63:0] sec_reg;                   // staged protect bits
  logic [63:0] prot_reg;                  // committed protect bits
  logic        secured_reg;               // security set
  logic        id_ready_reg;              // identity setup done
  logic [7:0]  rate_reg;                  // clock_rate_param
  logic [7:0]  block_reg;                 // selected block
  logic [23:0] cmd_reg;                   // command in hand
  logic [5:0]  idx_reg;                   // byte walk index
  logic [15:0] wait_reg;                  // operation timer

  wire [7:0]  c_op   = cmd_reg[23:16];
  wire [7:0]  c_arg  = cmd_reg[15:8];
  wire [7:0]  c_dat  = cmd_reg[7:0];
  wire        blk_locked  = secured_reg && prot_reg[block_reg[5:0]];
  wire [15:0] wait_cycles = 16'(rate_reg * UNIT_CYCLES);

  // one command at a time; the done toggle releases the poll
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      exec_reg <= E_IDLE;
      sec_reg <= 64'h0; prot_reg <= 64'h0;
      secured_reg <= 1'b0; id_ready_reg <= 1'b0;
      rate_reg <= CLOCK_RATE_RESET; block_reg <= 8'h00;
      cmd_reg <= 24'h000000; idx_reg <= 6'h00; wait_reg <= 16'h0000;
      reply_reg <= 16'h0000; reply_en_reg <= 1'b0; done_tog_reg <= 1'b0;
      pop_reg <= 1'b0;
      FL_ADDR <= 14'h0000; FL_WE <= 1'b0; FL_WDATA <= 8'h00; FL_ERASE <= 1'b0;
    end else begin
      pop_reg  <= 1'b0;
      FL_WE    <= 1'b0;
      FL_ERASE <= 1'b0;
      unique case (exec_reg)
        E_IDLE: begin
          if (fifo_out_valid && !pop_reg) begin
            cmd_reg  <= fifo_out_data;
            pop_reg  <= 1'b1;
            exec_reg <= E_EXEC;
          end
        end
        E_EXEC: begin
          reply_en_reg <= 1'b0;
          reply_reg    <= 16'h0000;
          wait_reg     <= 16'h0000;
          exec_reg     <= E_WAIT;
          if (c_op == CMD_WRITE_BYTE) begin
            page_reg[c_arg[5:0]] <= c_dat;
          end else if (c_op == CMD_CLOCK_RATE) begin
            rate_reg <= c_dat;
          end else if (c_op == CMD_SET_BLOCK) begin
            block_reg <= c_dat;
          end else if (c_op == CMD_ERASE_ALL && !secured_reg) begin
            // a secured part refuses mass erase
            FL_ERASE <= 1'b1;
            wait_reg <= wait_cycles;
          end else if (c_op == CMD_PROGRAM_BLOCK && !blk_locked) begin
            idx_reg  <= 6'h00;
            exec_reg <= E_WRITE;
          end else if (c_op == CMD_READ_BYTE) begin
            FL_ADDR  <= {block_reg, c_arg[5:0]};
            exec_reg <= E_READ;
          end else if (c_op == CMD_IDENTITY_SETUP) begin
            id_ready_reg <= 1'b1;
          end else if (c_op == CMD_IDENTITY_READ) begin
            reply_en_reg <= 1'b1;
            reply_reg    <= id_ready_reg ? IDENTITY_WORD : 16'h0000;
          end else if (c_op == CMD_WRITE_SECURITY) begin
            sec_reg[c_arg[5:0]] <= c_dat[0];
          end else if (c_op == CMD_PROTECT_COMMIT) begin
            prot_reg    <= sec_reg;
            secured_reg <= 1'b1;
            wait_reg    <= wait_cycles;
          end
        end
        E_WRITE: begin
          // stream the loaded block into the array
          FL_WE    <= 1'b1;
          FL_ADDR  <= {block_reg, idx_reg};
          FL_WDATA <= page_reg[idx_reg];
          idx_reg  <= idx_reg + 6'h01;
          if (idx_reg == BYTE_LAST) begin
            wait_reg <= wait_cycles;
            exec_reg <= E_WAIT;
          end
        end
        E_READ: begin
          // protected bytes read back as zero
          reply_en_reg <= 1'b1;
          reply_reg    <= {8'h00, blk_locked ? 8'h00 : FL_RDATA};
          exec_reg     <= E_WAIT;
        end
        E_WAIT: begin
          if (wait_reg != 16'h0000) begin
            wait_reg <= wait_reg - 16'h0001;
          end else begin
            done_tog_reg <= ~done_tog_reg;
            exec_reg     <= E_IDLE;
          end
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> bench/flash_supervisor_asserts.sv
// port level assertions for the flash supervisor
`timescale 1ns/10ps
`default_nettype none
module flash_supervisor_asserts
  import flash_supervisor_pkg::*;
(
  // clocks and reset
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic        PROG_SCLK,
  // cpu side
  input wire logic        CPU_OP_VALID,
  input wire logic [7:0]  CPU_OPCODE,
  input wire logic [7:0]  CPU_FLAGS,
  input wire logic [15:0] CPU_PC,
  input wire logic [7:0]  CPU_ACC,
  input wire logic        PC_LOAD,
  input wire logic [15:0] PC_NEXT,
  input wire logic        FLAGS_LOAD,
  input wire logic [7:0]  FLAGS_NEXT,
  input wire logic        STACK_PUSH,
  input wire logic [7:0]  STACK_DATA,
  // link pin
  input wire logic        PROG_DATA_OUT,
  input wire logic        PROG_DATA_OE
);
  // ----------------------------------------------------------------
  // call tracking
  // ----------------------------------------------------------------
  logic [2:0] age_reg;  // cycles since a call
  wire logic  idle      = (age_reg == 3'h0) || (age_reg == 3'h5);
  wire logic  take_call = CPU_OP_VALID && idle && (CPU_OPCODE == OPC_SUPERVISOR_CALL);
  wire logic  take_ret  = CPU_OP_VALID && idle && (CPU_OPCODE == OPC_RETURN_FROM_INT);
  // only idle calls restart the age
  always_ff @(posedge CLK) begin
    if (!RST_N)
      age_reg <= 3'h0;
    else if (take_call)
      age_reg <= 3'h1;
    else if (age_reg != 3'h0)
      age_reg <= (age_reg == 3'h5) ? 3'h0 : age_reg + 3'h1;
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property push_seq_p;
    logic [15:0] p;
    logic [7:0]  f;
    @(posedge CLK) disable iff (!RST_N)
    (take_call, p = CPU_PC, f = CPU_FLAGS) |-> ##1 (STACK_PUSH && STACK_DATA == p[15:8])
      ##1 (STACK_PUSH && STACK_DATA == p[7:0]) ##1 (STACK_PUSH && STACK_DATA == (f | 8'h08));
  endproperty
  call_push_a: assert property (push_seq_p) else $error("call push order wrong");
  call_entry_a: assert property (@(posedge CLK) disable iff (!RST_N)
    take_call |-> ##4 (FLAGS_LOAD && FLAGS_NEXT[3] && PC_LOAD && PC_NEXT == ROM_ENTRY_ADDR))
    else $error("call entry vector wrong");
  table_jump_a: assert property (@(posedge CLK) disable iff (!RST_N)
    take_call |-> ##5 (PC_LOAD && PC_NEXT == SERVICE_TABLE_BASE + {7'h00, $past(CPU_ACC, 5), 1'b0}))
    else $error("service table jump wrong");
  ret_clear_a: assert property (@(posedge CLK) disable iff (!RST_N)
    take_ret |-> ##1 (FLAGS_LOAD && FLAGS_NEXT == ($past(CPU_FLAGS) & 8'hf7)
      && PC_LOAD && PC_NEXT == $past(CPU_PC))) else $error("return did not restore");
  push_window_a: assert property (@(posedge CLK) disable iff (!RST_N)
    STACK_PUSH |-> (age_reg >= 3'h1 && age_reg <= 3'h3)) else $error("stray stack push");
  flag_bit_a: assert property (@(posedge CLK) disable iff (!RST_N)
    FLAGS_LOAD |-> (FLAGS_NEXT[3] == (age_reg == 3'h4))) else $error("flag 3 value wrong");
  link_busy_a: assert property (@(posedge PROG_SCLK) disable iff (!RST_N)
    $rose(PROG_DATA_OE) |-> PROG_DATA_OUT) else $error("link not busy high");
  link_done_a: assert property (@(posedge PROG_SCLK) disable iff (!RST_N)
    $rose(PROG_DATA_OE) |-> ##[1:1000] !PROG_DATA_OUT) else $error("link never done");
  // main scenarios reached
  call_seen_c: cover property (@(posedge CLK) disable iff (!RST_N) take_call ##5 PC_LOAD);
  ret_seen_c: cover property (@(posedge CLK) disable iff (!RST_N) take_ret ##1 FLAGS_LOAD);
  done_seen_c: cover property (@(posedge PROG_SCLK) disable iff (!RST_N)
    PROG_DATA_OE && $fell(PROG_DATA_OUT));
endmodule
bind flash_program_supervisor flash_supervisor_asserts chk_i (
  .CLK, .RST_N, .PROG_SCLK, .CPU_OP_VALID, .CPU_OPCODE, .CPU_FLAGS, .CPU_PC, .CPU_ACC,
  .PC_LOAD, .PC_NEXT, .FLAGS_LOAD, .FLAGS_NEXT, .STACK_PUSH, .STACK_DATA, .PROG_DATA_OUT,
  .PROG_DATA_OE);
`default_nettype wire

// >>> bench/serial_programmer_model.sv
// programmer model: link clock and data pin
`timescale 1ns/10ps
`default_nettype none
module serial_programmer_model
  import flash_supervisor_pkg::*;
(
  // link pins
  output logic     sclk,
  output logic     pin,
  input wire logic dev_out,
  input wire logic dev_oe
);
  logic host_val;  // host's line level
  initial begin
    sclk = 1'b0;
    host_val = 1'b0;
  end
  always #7.5 sclk = ~sclk;
  // line low when idle, yields to the device
  assign pin = dev_oe ? dev_out : host_val;
  // frame, poll, then reply of reads
  task automatic xfer(input logic [7:0] c, input logic [7:0] g, input logic [7:0] d,
                      output logic [15:0] reply, output logic ok);
    logic [23:0] frame;
    int          n;
    frame = {c, g, d};
    reply = 16'h0000;
    n = 0;
    @(negedge sclk) host_val = 1'b1;
    for (int i = 23; i >= 0; i--) @(negedge sclk) host_val = frame[i];
    @(negedge sclk) host_val = 1'b0;
    // poll: busy high until the device pulls low
    while (!(dev_oe && !dev_out) && n < 4000) @(negedge sclk) n++;
    if (c == CMD_READ_BYTE || c == CMD_IDENTITY_READ)
      for (int i = 15; i >= 0; i--) @(negedge sclk) reply[i] = pin;
    while (dev_oe && n < 4000) @(negedge sclk) n++;
    ok = (n < 4000);
    // gap for the input synchronisers
    repeat (4) @(negedge sclk);
  endtask
endmodule
`default_nettype wire

// >>> bench/test_flash_program_supervisor.sv
// self-checking bench for the flash programming supervisor
`timescale 1ns/10ps
`default_nettype none
module test_flash_program_supervisor;
  import flash_supervisor_pkg::*;
  localparam logic [7:0] ERASED = 8'hff;  // erased cell
  localparam logic [7:0] RATE   = 8'h05;  // 1 MHz times five
  logic             clk, rst_n, op_valid;
  logic [7:0]       opcode, flags, acc, fl_rdata, old;
  logic [15:0]      pc, rep;
  logic             ok;
  wire logic        pc_load, flags_load, push, fl_we, fl_erase, sclk, pin, d_out, d_oe;
  wire logic [15:0] pc_next;
  wire logic [7:0]  flags_next, push_data, fl_wdata;
  wire logic [13:0] fl_addr;
  logic [7:0]       flash [16384];  // array model
  logic [7:0]       pat [64];       // last block sent
  int               err_total, n_compared;
  always #5 clk = ~clk;
  // array reads at once; erase fills it
  assign fl_rdata = flash[fl_addr];
  always @(posedge clk) begin
    if (fl_we) flash[fl_addr] <= fl_wdata;
    if (fl_erase) foreach (flash[i]) flash[i] <= ERASED;
  end
  flash_program_supervisor flash_program_supervisor_i (
    .CLK(clk), .RST_N(rst_n), .CPU_OP_VALID(op_valid), .CPU_OPCODE(opcode),
    .CPU_FLAGS(flags), .CPU_PC(pc), .CPU_ACC(acc), .PC_LOAD(pc_load), .PC_NEXT(pc_next),
    .FLAGS_LOAD(flags_load), .FLAGS_NEXT(flags_next), .STACK_PUSH(push),
    .STACK_DATA(push_data), .FL_ADDR(fl_addr), .FL_WE(fl_we), .FL_WDATA(fl_wdata),
    .FL_ERASE(fl_erase), .FL_RDATA(fl_rdata), .PROG_SCLK(sclk), .PROG_DATA_IN(pin),
    .PROG_DATA_OUT(d_out), .PROG_DATA_OE(d_oe));
  serial_programmer_model serial_programmer_model_i (
    .sclk(sclk), .pin(pin), .dev_out(d_out), .dev_oe(d_oe));
  // compare and count
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // table slot for ACC
  function automatic logic [15:0] table_pc(input logic [7:0] a);
    return SERVICE_TABLE_BASE + {7'h00, a, 1'b0};
  endfunction
  // one call or return; a return mid-call is ignored
  task automatic cpu_op(input logic [7:0] op);
    logic [15:0] p;
    logic [7:0]  f, a;
    p = 16'($urandom);
    f = 8'($urandom);
    a = 8'($urandom);
    @(negedge clk);
    {op_valid, opcode, pc, flags, acc} = {1'b1, op, p, f, a};
    @(negedge clk);
    op_valid = 1'b0;
    if (op == OPC_RETURN_FROM_INT) begin
      check("ret flags", {pc_load, flags_load, 6'h0, flags_next}, {8'hc0, f & 8'hf7});
      check("ret pc", pc_next, p);
    end else begin
      check("push hi", {push, 7'h0, push_data}, {8'h80, p[15:8]});
      {op_valid, opcode} = {1'b1, OPC_RETURN_FROM_INT};
      @(negedge clk);
      op_valid = 1'b0;
      check("push lo", {push, flags_load, 6'h0, push_data}, {8'h80, p[7:0]});
      @(negedge clk);
      check("push flags", {push, flags_load, 6'h0, push_data}, {8'h80, f | 8'h08});
      @(negedge clk);
      check("entry", {pc_load, flags_load, 6'h0, flags_next}, {8'hc0, f | 8'h08});
      check("entry pc", pc_next, ROM_ENTRY_ADDR);
      @(negedge clk);
      check("table pc", pc_next, table_pc(a));
      check("table load", {15'h0, pc_load}, 16'h0001);
    end
  endtask
  // one link step
  task automatic link(input logic [7:0] c, input logic [7:0] g, input logic [7:0] d);
    serial_programmer_model_i.xfer(c, g, d, rep, ok);
    if (ok !== 1'b1) begin
      err_total++;
      conclude();
    end
  endtask
  task automatic program_block(input logic [7:0] blk);
    for (int i = 0; i < 64; i++) begin
      pat[i] = 8'($urandom);
      link(CMD_WRITE_BYTE, 8'(i), pat[i]);
    end
    link(CMD_CLOCK_RATE, 8'h00, RATE);
    link(CMD_SET_BLOCK, 8'h00, blk);
    link(CMD_PROGRAM_BLOCK, 8'h00, 8'h00);
  endtask
  // watchdog well past the expected run
  initial begin
    #900000;
    err_total++;
    conclude();
  end
  initial begin
    {clk, rst_n, op_valid, opcode, flags, pc, acc} = '0;
    err_total = 0;
    n_compared = 0;
    foreach (flash[i]) flash[i] = 8'h00;
    void'($urandom(6921));
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    repeat (40) cpu_op($urandom_range(0, 1) ? OPC_SUPERVISOR_CALL : OPC_RETURN_FROM_INT);
    link(CMD_IDENTITY_SETUP, 8'h00, 8'h00);
    link(CMD_IDENTITY_READ, 8'h00, 8'h00);
    check("identity", rep, IDENTITY_WORD);
    link(CMD_CLOCK_RATE, 8'h00, RATE);
    link(CMD_ERASE_ALL, 8'h00, 8'h00);
    check("erased", {8'h00, flash[14'h0041]}, {8'h00, ERASED});
    program_block(8'h01);
    link(CMD_SET_BLOCK, 8'h00, 8'h01);
    link(CMD_VERIFY_SETUP, 8'h00, 8'h00);
    for (int i = 0; i < 64; i++) begin
      link(CMD_READ_BYTE, 8'(i), 8'h00);
      check("readback", rep, {8'h00, pat[i]});
    end
    for (int i = 0; i < 64; i++) link(CMD_WRITE_SECURITY, 8'(i), {7'h00, i == 1});
    link(CMD_CLOCK_RATE, 8'h00, RATE);
    link(CMD_PROTECT_COMMIT, 8'h00, 8'h00);
    old = pat[5];
    link(CMD_READ_BYTE, 8'h05, 8'h00);
    check("locked read", rep, 16'h0000);
    program_block(8'h01);
    link(CMD_ERASE_ALL, 8'h00, 8'h00);
    check("locked keep", {8'h00, flash[14'h0045]}, {8'h00, old});
    check("erase held", {8'h00, flash[14'h0003]}, {8'h00, ERASED});
    link(CMD_SET_BLOCK, 8'h00, 8'h00);
    link(CMD_READ_BYTE, 8'h03, 8'h00);
    check("open read", rep, {8'h00, ERASED});
    conclude();
  end
endmodule
`default_nettype wire
